// ===== hw/output_compare_unit.sv
// output compare unit top: apb registers, timer, trigger, fault, pin
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module output_compare_unit import oc_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_idle,
   input wire pins_t pins,
   output logic compare_output_pin,
   output logic compare_output_oe,
   output logic compare_irq
);
   // ****************************************
   // synchronised inputs
   // ****************************************
   pins_t pin_s;
   pins_t pin_d_r;
   oc_sync2 u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(clk_en),
      .d(pins),
      .q(pin_s)
   );
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pin_d_r <= '0;
      else if (clk_en) pin_d_r <= pin_s;
   end
   function automatic logic rise(input logic now_v, input logic was_v);
      return now_v & ~was_v;
   endfunction

   // ****************************************
   // registers
   // ****************************************
   logic [15:0] ctl_one_r;
   logic [15:0] ctl_two_r;
   logic [15:0] cmp_a_r;
   logic [15:0] cmp_b_r;
   logic [15:0] cmp_a_buf_r;
   logic [15:0] cmp_b_buf_r;
   logic [15:0] timer_r;
   logic [15:0] timer_nxt;
   logic fault_active_r;
   logic irq_flag_r;
   mode_t mode;
   logic pwm_mode;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic match_a;
   logic match_b;
   logic wave;
   logic tick;
   logic src_evt;
   logic fault_in;
   logic period_start;
   logic run;
   logic restart;
   logic restart_r;
   wave_cfg_t cfg;

   assign mode = mode_t'(ctl_one_r[mode_lsb +: 3]);
   assign pwm_mode = (mode == mode_epwm) || (mode == mode_cpwm);
   assign addr_ok = (paddr == ctl_one_addr) || (paddr == ctl_two_addr) ||
                    (paddr == cmp_a_addr) || (paddr == cmp_b_addr) ||
                    (paddr == timer_addr) || (paddr == status_addr);
   assign wr_en = psel && penable && pwrite && pready && addr_ok && clk_en;
   assign rd_en = psel && !penable && !pwrite;

   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb,
                                        input logic [15:0] mask);
      logic [15:0] m;
      m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      return (old_v & ~m) | (new_v[15:0] & m);
   endfunction

   // ****************************************
   // apb slave
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && rd_en) begin
         unique case (paddr)
            ctl_one_addr: prdata <= {16'h0000, ctl_one_r};
            ctl_two_addr: prdata <= {16'h0000, ctl_two_r};
            cmp_a_addr: prdata <= {16'h0000, cmp_a_buf_r};
            cmp_b_addr: prdata <= {16'h0000, cmp_b_buf_r};
            timer_addr: prdata <= {16'h0000, timer_r};
            status_addr: prdata <= {30'h0000_0000, fault_active_r, irq_flag_r};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // control one; fault flag set wins over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_one_r <= ctl_one_rst;
      end else if (clk_en) begin
         if (wr_en && paddr == ctl_one_addr)
            ctl_one_r <= merge(ctl_one_r, pwdata, pstrb, ctl_one_wmask);
         if (ctl_one_r[fault_en_bit] && fault_in)
            ctl_one_r[fault_flag_bit] <= 1'b1;
      end
   end

   // control two; trigger status set wins over any clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_two_r <= ctl_two_rst;
      end else if (clk_en) begin
         if (wr_en && paddr == ctl_two_addr)
            ctl_two_r <= merge(ctl_two_r, pwdata, pstrb, ctl_two_wmask);
         if (run && ctl_one_r[trig_mode_bit] && match_b && ctl_two_r[trig_sel_bit])
            ctl_two_r[trig_stat_bit] <= 1'b0;
         if (ctl_two_r[trig_sel_bit] && src_evt)
            ctl_two_r[trig_stat_bit] <= 1'b1;
      end
   end

   // compare values: buffered copies load at period start in pwm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_a_buf_r <= 16'h0000;
         cmp_b_buf_r <= 16'h0000;
         cmp_a_r <= 16'h0000;
         cmp_b_r <= 16'h0000;
      end else if (clk_en) begin
         if (wr_en && paddr == cmp_a_addr)
            cmp_a_buf_r <= merge(cmp_a_buf_r, pwdata, pstrb, 16'hFFFF);
         if (wr_en && paddr == cmp_b_addr)
            cmp_b_buf_r <= merge(cmp_b_buf_r, pwdata, pstrb, 16'hFFFF);
         if (!pwm_mode || period_start) begin
            cmp_a_r <= cmp_a_buf_r;
            cmp_b_r <= cmp_b_buf_r;
         end
      end
   end

   // ****************************************
   // time base and trigger source
   // ****************************************
   always_comb begin
      unique case (clk_sel_t'(ctl_one_r[clk_sel_lsb +: 3]))
         clk_periph: tick = 1'b1;
         clk_t1: tick = rise(pin_s.timer_one_clock, pin_d_r.timer_one_clock);
         clk_t2: tick = rise(pin_s.timer_two_clock, pin_d_r.timer_two_clock);
         clk_t3: tick = rise(pin_s.timer_three_clock, pin_d_r.timer_three_clock);
         default: tick = 1'b0;
      endcase
   end

   always_comb begin
      unique case (ctl_two_r[src_lsb +: 5])
         src_capture: src_evt = rise(pin_s.capture_evt, pin_d_r.capture_evt);
         src_timer1: src_evt = rise(pin_s.timer1_evt, pin_d_r.timer1_evt);
         src_timer2: src_evt = rise(pin_s.timer2_evt, pin_d_r.timer2_evt);
         src_timer3: src_evt = rise(pin_s.timer3_evt, pin_d_r.timer3_evt);
         src_cap_irq: src_evt = rise(pin_s.capture_irq_evt, pin_d_r.capture_irq_evt);
         src_analog_comparator_one: src_evt = rise(pin_s.analog_comparator_one,
                                  pin_d_r.analog_comparator_one);
         src_analog_comparator_two: src_evt = rise(pin_s.analog_comparator_two,
                                  pin_d_r.analog_comparator_two);
         src_external_interrupt_one: src_evt = rise(pin_s.external_interrupt_one,
                                  pin_d_r.external_interrupt_one);
         src_external_interrupt_two: src_evt = rise(pin_s.external_interrupt_two,
                                  pin_d_r.external_interrupt_two);
         src_own: src_evt = match_b && tick;
         default: src_evt = 1'b0;
      endcase
   end

   assign fault_in = pin_s.fault_input_pin;
   assign run = clk_en && !(cpu_idle && ctl_one_r[stop_idle_bit]) && mode != mode_off;
   assign period_start = tick && (timer_r == 16'h0000);

   always_comb begin
      timer_nxt = timer_r;
      if (ctl_two_r[trig_sel_bit] && !ctl_two_r[trig_stat_bit])
         timer_nxt = 16'h0000;
      else if (!ctl_two_r[trig_sel_bit] && src_evt)
         timer_nxt = 16'h0000;
      else if (tick && pwm_mode && match_b)
         timer_nxt = 16'h0000;
      else if (tick)
         timer_nxt = 16'(timer_r + 16'h0001);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) timer_r <= 16'h0000;
      else if (run) timer_r <= timer_nxt;
      else if (clk_en && mode == mode_off) timer_r <= 16'h0000;
   end

   // ****************************************
   // waveform, fault and pin
   // ****************************************
   assign cfg = '{mode: mode, cmp_a: cmp_a_r, cmp_b: cmp_b_r};
   // restart a cycle after the write, so the generator sees the new mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) restart_r <= 1'b0;
      else if (clk_en) restart_r <= wr_en && paddr == ctl_one_addr;
   end
   assign restart = clk_en && restart_r;

   oc_wave u_wave (
      .pclk(pclk),
      .presetn(presetn),
      .run(run && tick),
      .restart(restart),
      .cfg(cfg),
      .timer(timer_r),
      .wave(wave),
      .match_a(match_a),
      .match_b(match_b)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_active_r <= 1'b0;
      end else if (clk_en) begin
         if (ctl_one_r[fault_en_bit] && fault_in)
            fault_active_r <= 1'b1;
         else if (fault_active_r && period_start && !fault_in &&
                  !(ctl_two_r[fault_mode_bit] && ctl_one_r[fault_flag_bit]))
            fault_active_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_output_pin <= 1'b0;
         compare_output_oe <= 1'b0;
      end else if (clk_en) begin
         if (fault_active_r) begin
            compare_output_pin <= ctl_two_r[fault_out_bit];
            compare_output_oe <= !ctl_two_r[tri_fault_bit] && !ctl_two_r[out_tri_bit];
         end else begin
            compare_output_pin <= wave ^ ctl_two_r[invert_bit];
            compare_output_oe <= !ctl_two_r[out_tri_bit];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_r <= 1'b0;
         compare_irq <= 1'b0;
      end else if (clk_en) begin
         if (run && tick && (match_a || (match_b && mode >= mode_one_pulse)))
            irq_flag_r <= 1'b1;
         else if (wr_en && paddr == status_addr && pwdata[0])
            irq_flag_r <= 1'b0;
         compare_irq <= irq_flag_r;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   off_no_wave_a: assert property (mode == mode_off && $past(mode == mode_off) && clk_en
      |=> !wave) else $error("wave active while disabled");
   tri_pin_a: assert property (clk_en && ctl_two_r[out_tri_bit] |=> !compare_output_oe)
      else $error("pin driven while tristated");
   fault_level_a: assert property (clk_en && fault_active_r && !ctl_two_r[tri_fault_bit]
      && !ctl_two_r[out_tri_bit] |=> compare_output_oe &&
      compare_output_pin == $past(ctl_two_r[fault_out_bit]))
      else $error("fault level wrong");
   fault_float_a: assert property (clk_en && fault_active_r && ctl_two_r[tri_fault_bit]
      |=> !compare_output_oe) else $error("pin not floated on fault");
   fault_flag_set_a: assert property (clk_en && ctl_one_r[fault_en_bit] && fault_in
      |=> ctl_one_r[fault_flag_bit] && fault_active_r)
      else $error("fault flag not set");
   fault_ignored_a: assert property (clk_en && !ctl_one_r[fault_en_bit] && !fault_active_r
      |=> !fault_active_r) else $error("fault seen while disabled");
   trig_hold_a: assert property (run && ctl_two_r[trig_sel_bit] && !ctl_two_r[trig_stat_bit]
      |=> timer_r == 16'h0000) else $error("timer ran untriggered");
   idle_halt_a: assert property (cpu_idle && ctl_one_r[stop_idle_bit] |=> $stable(timer_r))
      else $error("timer ran in idle");
   invert_out_a: assert property (clk_en && !fault_active_r |=>
      compare_output_pin == ($past(wave) ^ $past(ctl_two_r[invert_bit])))
      else $error("inversion wrong");
   epwm_high_c: cover property (mode == mode_epwm && wave ##[1:200] !wave);
   fault_c: cover property (fault_active_r ##1 !fault_active_r);
   trig_c: cover property (ctl_two_r[trig_sel_bit] && src_evt);
endmodule

// ===== hw/oc_pkg.sv
// constants, types and register layout of the output compare unit
// Function
// - mode 000 disables the channel; no waveform activity on the pin.
// - mode 001 starts low, sets high on match A; 010 starts high, clears.
// - mode 011 toggles the output on every compare_a match.
// - mode 100 starts low, toggles on A then B, one pulse only.
// - mode 101 starts low, toggles on alternate A and B matches forever.
// - mode 110 edge PWM: high at timer zero, low at compare_a.
// - mode 111 center PWM: high at compare_a, low at compare_b.
// - compare values double-buffered only in PWM modes, else written directly.
// - clock select 111 peripheral, 100 timer1, 001 timer3, 000 timer2.
// - stop-in-idle set halts the timer and waveform while the processor idles.
// - fault input is watched only while fault enable is set.
// - hardware sets fault flag on fault; software reads and writes it.
// - fault mode 1 also needs flag cleared; both need source gone, new period.
// - during fault without tristate, output driven to fault-out level.
// - tristate-on-fault floats the pin for the whole fault.
// - invert bit inverts the generated waveform before the pin.
// - output tristate bit floats the pin; clear lets the unit drive it unless tristate-on-fault floats it in a fault.
// - trigger/sync select 1 triggers the timer, 0 synchronises it.
// - trigger status set by source; clear holds timer at zero; software writable.
// - trigger status mode 1 also clears status on compare_b timer match.
// - source 01100 timer2 is default; 11111 own compare_b; 00000 none.
// - other sources: capture irq, capture, analog comp 1, analog comp 2, ext int 2, ext int 1, timer3, timer1.
// - the unit can raise an interrupt request on compare matches.
package oc_pkg;
   localparam logic [11:0] ctl_one_addr = 12'h000;
   localparam logic [11:0] ctl_two_addr = 12'h004;
   localparam logic [11:0] cmp_a_addr = 12'h008;
   localparam logic [11:0] cmp_b_addr = 12'h00C;
   localparam logic [11:0] timer_addr = 12'h010;
   localparam logic [11:0] status_addr = 12'h014;
   // control one fields
   localparam int stop_idle_bit = 13;
   localparam int clk_sel_lsb = 10;
   localparam int fault_en_bit = 7;
   localparam int fault_flag_bit = 4;
   localparam int trig_mode_bit = 3;
   localparam int mode_lsb = 0;
   // control two fields
   localparam int fault_mode_bit = 15;
   localparam int fault_out_bit = 14;
   localparam int tri_fault_bit = 13;
   localparam int invert_bit = 12;
   localparam int trig_sel_bit = 7;
   localparam int trig_stat_bit = 6;
   localparam int out_tri_bit = 5;
   localparam int src_lsb = 0;
   localparam logic [15:0] ctl_one_rst = 16'h0000;
   localparam logic [15:0] ctl_two_rst = 16'h000C;
   localparam logic [15:0] ctl_one_wmask = 16'h3C9F;
   localparam logic [15:0] ctl_two_wmask = 16'hF0FF;
   typedef enum logic [2:0] {
      mode_off = 3'h0, mode_set_hi = 3'h1, mode_set_lo = 3'h2, mode_toggle = 3'h3,
      mode_one_pulse = 3'h4, mode_pulses = 3'h5, mode_epwm = 3'h6, mode_cpwm = 3'h7
   } mode_t;
   typedef enum logic [2:0] {
      clk_t2 = 3'h0, clk_t3 = 3'h1, clk_t1 = 3'h4, clk_periph = 3'h7
   } clk_sel_t;
   localparam logic [4:0] src_none = 5'h00;
   localparam logic [4:0] src_capture = 5'h05;
   localparam logic [4:0] src_timer1 = 5'h0B;
   localparam logic [4:0] src_timer2 = 5'h0C;
   localparam logic [4:0] src_timer3 = 5'h0D;
   localparam logic [4:0] src_cap_irq = 5'h10;
   localparam logic [4:0] src_analog_comparator_one = 5'h18;
   localparam logic [4:0] src_analog_comparator_two = 5'h19;
   localparam logic [4:0] src_external_interrupt_one = 5'h1D;
   localparam logic [4:0] src_external_interrupt_two = 5'h1E;
   localparam logic [4:0] src_own = 5'h1F;
   // pin-side event inputs, bundled
   typedef struct packed {
      logic timer_one_clock;
      logic timer_two_clock;
      logic timer_three_clock;
      logic timer1_evt;
      logic timer2_evt;
      logic timer3_evt;
      logic capture_evt;
      logic capture_irq_evt;
      logic analog_comparator_one;
      logic analog_comparator_two;
      logic external_interrupt_one;
      logic external_interrupt_two;
      logic fault_input_pin;
   } pins_t;
   // waveform generator controls
   typedef struct packed {
      mode_t mode;
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
   } wave_cfg_t;
endpackage

// ===== hw/oc_sync2.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module oc_sync2 import oc_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire pins_t d,
   output pins_t q
);
   pins_t meta_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q <= '0;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ===== hw/oc_wave.sv
// waveform generator: compare matches to raw output level
`timescale 1ns/10ps
module oc_wave import oc_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic restart,
   input wire wave_cfg_t cfg,
   input wire logic [15:0] timer,
   output logic wave,
   output logic match_a,
   output logic match_b
);
   logic done_r;
   logic phase_b_r;
   assign match_a = (timer == cfg.cmp_a);
   assign match_b = (timer == cfg.cmp_b);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave <= 1'b0;
         done_r <= 1'b0;
         phase_b_r <= 1'b0;
      end else if (restart) begin
         wave <= (cfg.mode == mode_set_lo);
         done_r <= 1'b0;
         phase_b_r <= 1'b0;
      end else if (run) begin
         unique case (cfg.mode)
            mode_off: wave <= 1'b0;
            mode_set_hi: if (match_a) wave <= 1'b1;
            mode_set_lo: if (match_a) wave <= 1'b0;
            mode_toggle: if (match_a) wave <= ~wave;
            mode_one_pulse: begin
               if (!done_r && !phase_b_r && match_a) begin
                  wave <= 1'b1;
                  phase_b_r <= 1'b1;
               end else if (!done_r && phase_b_r && match_b) begin
                  wave <= 1'b0;
                  done_r <= 1'b1;
               end
            end
            mode_pulses: begin
               if (!phase_b_r && match_a) begin
                  wave <= ~wave;
                  phase_b_r <= 1'b1;
               end else if (phase_b_r && match_b) begin
                  wave <= ~wave;
                  phase_b_r <= 1'b0;
               end
            end
            mode_epwm: begin
               if (timer == 16'h0000) wave <= 1'b1;
               else if (match_a) wave <= 1'b0;
            end
            mode_cpwm: begin
               if (match_a) wave <= 1'b1;
               else if (match_b) wave <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ===== tb/oc_load.sv
// external load on the compare output pin, with a pull-down
`timescale 1ns/10ps
module oc_load (
   input wire logic pclk,
   input wire logic drive,
   input wire logic oe,
   output logic level,
   output int edges
);
   logic last = 1'h0;
   int cnt = 0;
   // a released pin is pulled low by the load
   assign level = oe ? drive : 1'h0;
   assign edges = cnt;
   always @(posedge pclk) begin
      if (level !== last) begin
         cnt <= cnt + 1;
      end
      last <= level;
   end
endmodule

// ===== tb/tb.sv
// self-checking bench for the output compare unit
`timescale 1ns/10ps
module tb import oc_pkg::*; ;
   // ****************
   // signals
   // ****************
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, cpu_idle = 1'h0, pready, pslverr, pin, oe, irq, level, err;
   logic ce = 1'h1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   pins_t pins = '0;
   int edges, e0, num_errors = 0, cmp_count = 0, cycles = 0;
   always #5 pclk = ~pclk;
   output_compare_unit i_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .pins(pins),
      .compare_output_pin(pin), .compare_output_oe(oe), .compare_irq(irq));
   oc_load i_load (.pclk(pclk), .drive(pin), .oe(oe), .level(level), .edges(edges));
   // ****************
   // tasks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) begin
         @(posedge pclk);
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      apb(1'h1, a, {16'h0, d});
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rdat, {16'h0, exp});
   endtask
   task automatic hold(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic wait_pin(input logic v);
      int n;
      n = 0;
      while (level !== v && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk1(level, v);
   endtask
   task automatic high_len(input int exp);
      int n;
      n = 0;
      while (level === 1'h1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk(n, exp);
   endtask
   // timer held at zero while compares and mode load, then released
   task automatic go(input logic [15:0] c1, c2, a, b);
      wr(ctl_two_addr, c2 | 16'h0080);
      wr(cmp_a_addr, a);
      wr(cmp_b_addr, b);
      wr(ctl_one_addr, c1 | 16'h1C00);
      wr(ctl_two_addr, c2 | 16'h00C0);
   endtask
   task automatic give_verdict();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   // ****************
   // sequence
   // ****************
   initial begin
      hold(20);
      presetn <= 1'h1;
      hold(1);
      rd(ctl_one_addr, 16'h0000);
      rd(ctl_two_addr, 16'h000C);
      rd(timer_addr, 16'h0000);
      rd(12'h020, 16'h0000);
      chk1(err, 1'h1);
      go(16'h0000, 16'h0000, 16'h0003, 16'h0006);
      hold(3);
      e0 = edges;
      hold(40);
      chk(edges - e0, 0);
      go(16'h0001, 16'h0000, 16'h012C, 16'h0200);
      chk1(level, 1'h0);
      wr(cmp_a_addr, 16'h001E);
      wait_pin(1'h1);
      go(16'h0002, 16'h0000, 16'h0005, 16'h0009);
      chk1(level, 1'h1);
      wait_pin(1'h0);
      go(16'h0003, 16'h0000, 16'h0005, 16'h0009);
      wait_pin(~level);
      go(16'h0004, 16'h0000, 16'h0005, 16'h000A);
      e0 = edges;
      wait_pin(1'h1);
      wait_pin(1'h0);
      hold(60);
      chk(edges - e0, 2);
      go(16'h0005, 16'h0000, 16'h0005, 16'h000A);
      chk1(level, 1'h0);
      wait_pin(1'h1);
      wait_pin(1'h0);
      go(16'h0006, 16'h0000, 16'h0004, 16'h0009);
      wait_pin(1'h0);
      wait_pin(1'h1);
      high_len(4);
      go(16'h0007, 16'h0000, 16'h0003, 16'h0008);
      wait_pin(1'h0);
      wait_pin(1'h1);
      high_len(5);
      go(16'h0001, 16'h1000, 16'h0005, 16'h0009);
      chk1(level, 1'h1);
      wait_pin(1'h0);
      wr(ctl_two_addr, 16'h00E0);
      hold(3);
      chk1(oe, 1'h0);
      wr(ctl_two_addr, 16'h00C0);
      hold(3);
      chk1(oe, 1'h1);
      go(16'h0009, 16'h0000, 16'h0003, 16'h0006);
      hold(30);
      rd(ctl_two_addr, 16'h0080);
      rd(timer_addr, 16'h0000);
      go(16'h0086, 16'h4000, 16'h0004, 16'h0009);
      pins.fault_input_pin <= 1'h1;
      hold(20);
      e0 = edges;
      hold(30);
      chk(edges - e0, 0);
      chk1(level, 1'h1);
      rd(ctl_one_addr, 16'h1C96);
      wr(ctl_two_addr, 16'h60C0);
      hold(5);
      chk1(oe, 1'h0);
      pins.fault_input_pin <= 1'h0;
      wait_pin(1'h1);
      wait_pin(1'h0);
      go(16'h0006, 16'h0000, 16'h0004, 16'h0009);
      pins.fault_input_pin <= 1'h1;
      hold(20);
      wait_pin(1'h0);
      wait_pin(1'h1);
      rd(ctl_one_addr, 16'h1C06);
      pins.fault_input_pin <= 1'h0;
      go(16'h2001, 16'h0000, 16'h0020, 16'h0040);
      cpu_idle <= 1'h1;
      hold(60);
      chk1(level, 1'h0);
      cpu_idle <= 1'h0;
      wait_pin(1'h1);
      // clock enable low freezes the timer, so no match during the hold
      go(16'h0001, 16'h0000, 16'h0020, 16'h0040);
      ce <= 1'h0;
      hold(60);
      chk1(level, 1'h0);
      ce <= 1'h1;
      wait_pin(1'h1);
      give_verdict();
   end
endmodule
